// [shared/csp_pkg.sv]
/*
 * Constants and carrier types for the pin-mode serial configuration port.
 * Assumes one 16-bit frame per enable window: 8-bit address, then 8-bit data, msb first.
 */
package csp_pkg;
   // ==========================================================
   // frame layout
   localparam int unsigned CSP_ADDR_BITS  = 8;
   localparam int unsigned CSP_DATA_BITS  = 8;
   localparam int unsigned CSP_FRAME_BITS = CSP_ADDR_BITS + CSP_DATA_BITS;
   localparam int unsigned CSP_CNT_BITS   = 4;
   localparam logic [3:0]  CSP_ADDR_LAST  = 4'h7;
   localparam logic [3:0]  CSP_FRAME_LAST = 4'hF;
   // ==========================================================
   // register map
   localparam int unsigned CSP_NUM_REGS   = 4;
   localparam logic [7:0]  CSP_ADDR_CTRL  = 8'h00;
   localparam logic [7:0]  CSP_ADDR_PWR   = 8'h01;
   localparam logic [7:0]  CSP_ADDR_GEN0  = 8'h02;
   localparam logic [7:0]  CSP_ADDR_GEN1  = 8'h03;
   localparam int unsigned CSP_CTRL_SWRST = 0;
   localparam int unsigned CSP_CTRL_RDSEL = 1;
   localparam int unsigned CSP_PWR_STBY   = 0;
   localparam logic [7:0]  CSP_RST_CTRL   = 8'h00;
   localparam logic [7:0]  CSP_RST_PWR    = 8'h00;
   localparam logic [7:0]  CSP_RST_GEN    = 8'h00;
   localparam int unsigned CSP_SYNC_STAGES = 2;

   typedef struct packed {
      logic [CSP_ADDR_BITS-1:0] addr;
      logic [CSP_DATA_BITS-1:0] data;
   } csp_frame_type;

   typedef struct packed {
      logic [7:0] gen1;
      logic [7:0] gen0;
      logic [7:0] pwr;
      logic [7:0] ctrl;
   } csp_cfg_type;

   localparam csp_cfg_type CSP_CFG_RESET = '{gen1: CSP_RST_GEN, gen0: CSP_RST_GEN,
                                             pwr: CSP_RST_PWR, ctrl: CSP_RST_CTRL};
endpackage

// [core/csp_sync2.sv]
/*
 * Two-flop level synchroniser, parameterised width.
 * Assumes each bit is an independent level or a toggle; no multi-bit coherence.
 */
`timescale 1ns/1ps
module csp_sync2 #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // level in and out
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule

// [core/csp_port.sv]
/*
 * Serial configuration port with pin-level mode select.
 * Reset pin low: serial clock, data and enable form a register-write port.
 * Reset pin high: registers held at defaults, data pin acts as standby control.
 * Assumes the serial clock runs only inside enable windows and that the
 * overrange flag is synchronous to sys_clk_i.
 */
`timescale 1ns/1ps
// Functional notes
// - shared pin: overrange if select 0, readback if 1
// - reset pin high holds registers at defaults
// - serial clock used only while reset pin low
// - data pin: serial data, else standby control
// - enable pin frames transfers only in serial mode
module csp_port
   import csp_pkg::*;
(
   // system clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       sys_rst_i,
   // configuration pins
   input  wire logic       config_reset_pin_i,
   input  wire logic       config_serial_clk_i,
   input  wire logic       config_serial_data_in_i,
   input  wire logic       config_serial_enable_n_i,
   output logic            overrange_or_readback_out_o,
   // converter side
   input  wire logic       overrange_flag_i,
   output logic            hw_mode_o,
   output logic            standby_o,
   output logic [7:0]      cfg_gen0_o,
   output logic [7:0]      cfg_gen1_o
);
   // ==========================================================
   // link domain resets
   logic link_rst;
   logic frame_rst;

   assign link_rst  = sys_rst_i | config_reset_pin_i;
   assign frame_rst = link_rst | config_serial_enable_n_i;

   // ==========================================================
   // link domain: frame shifter
   logic [CSP_CNT_BITS-1:0]   bit_cnt_q;
   logic [CSP_FRAME_BITS-2:0] shift_q;
   logic [CSP_DATA_BITS-1:0]  rb_shift_q;
   logic                      addr_done;
   logic                      frame_done;
   csp_frame_type             frame;
   logic [CSP_ADDR_BITS-1:0]  rd_addr;
   logic                      rd_valid;
   logic [CSP_DATA_BITS-1:0]  rd_data;

   logic [7:0]                regs_q [CSP_NUM_REGS];
   csp_cfg_type               regs_flat;

   assign addr_done  = (bit_cnt_q == CSP_ADDR_LAST);
   assign frame_done = (bit_cnt_q == CSP_FRAME_LAST);
   assign frame      = {shift_q, config_serial_data_in_i};
   assign rd_addr    = {shift_q[CSP_ADDR_BITS-2:0], config_serial_data_in_i};
   assign rd_valid   = (rd_addr < CSP_ADDR_BITS'(CSP_NUM_REGS));
   assign rd_data    = rd_valid ? regs_q[rd_addr[1:0]] : '0;

   // counter and shifters clear whenever the enable is high
   always_ff @(posedge config_serial_clk_i or posedge frame_rst) begin
      if (frame_rst) begin
         bit_cnt_q <= '0;
         shift_q   <= '0;
      end else begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
         shift_q   <= frame[CSP_FRAME_BITS-2:0];
      end
   end

   always_ff @(posedge config_serial_clk_i or posedge frame_rst) begin
      if (frame_rst) begin
         rb_shift_q <= '0;
      end else if (addr_done) begin
         rb_shift_q <= rd_data;
      end else begin
         rb_shift_q <= {rb_shift_q[CSP_DATA_BITS-2:0], 1'b0};
      end
   end

   // ==========================================================
   // link domain: register file
   logic wr_ctrl;
   logic sw_reset;
   logic wr_ok;
   logic upd_tgl_q;

   assign wr_ctrl  = (frame.addr == CSP_ADDR_CTRL);
   assign sw_reset = frame_done & wr_ctrl & frame.data[CSP_CTRL_SWRST];
   // while readback is selected only the control register is writable
   assign wr_ok    = frame_done & (frame.addr < CSP_ADDR_BITS'(CSP_NUM_REGS))
                     & (~regs_q[0][CSP_CTRL_RDSEL] | wr_ctrl);

   always_ff @(posedge config_serial_clk_i or posedge link_rst) begin
      if (link_rst) begin
         regs_q[0] <= CSP_RST_CTRL;
         regs_q[1] <= CSP_RST_PWR;
         regs_q[2] <= CSP_RST_GEN;
         regs_q[3] <= CSP_RST_GEN;
      end else if (sw_reset) begin
         regs_q[0] <= CSP_RST_CTRL;
         regs_q[1] <= CSP_RST_PWR;
         regs_q[2] <= CSP_RST_GEN;
         regs_q[3] <= CSP_RST_GEN;
      end else if (wr_ok) begin
         regs_q[frame.addr[1:0]] <= frame.data;
      end
   end

   // one toggle per completed frame; the snapshot stays still until the next frame, or until hw mode loads it with defaults
   always_ff @(posedge config_serial_clk_i or posedge link_rst) begin
      if (link_rst) begin
         upd_tgl_q <= 1'b0;
      end else if (frame_done) begin
         upd_tgl_q <= ~upd_tgl_q;
      end
   end

   assign regs_flat = {regs_q[3], regs_q[2], regs_q[1], regs_q[0]};

   // ==========================================================
   // system domain: synchronisers
   logic [2:0] pins_s;
   logic       hw_mode_s;
   logic       stby_pin_s;
   logic       upd_tgl_s;

   csp_sync2 #(
      .WIDTH (3)
   ) u_sync (
      .clk_i (sys_clk_i),
      .rst_i (sys_rst_i),
      .d_i   ({upd_tgl_q, config_serial_data_in_i, config_reset_pin_i}),
      .q_o   (pins_s)
   );

   assign hw_mode_s  = pins_s[0];
   assign stby_pin_s = pins_s[1];
   assign upd_tgl_s  = pins_s[2];

   // ==========================================================
   // system domain: configuration snapshot
   logic        tgl_prev_q;
   logic        take;
   csp_cfg_type cfg_q;
   csp_cfg_type cfg_d;
   logic        stby_d;
   logic        stby_q;
   logic        ovr_q;

   assign take  = upd_tgl_s ^ tgl_prev_q;
   assign cfg_d = hw_mode_s ? CSP_CFG_RESET : (take ? regs_flat : cfg_q);
   assign stby_d = hw_mode_s ? stby_pin_s : cfg_q.pwr[CSP_PWR_STBY];

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tgl_prev_q <= 1'b0;
         cfg_q      <= CSP_CFG_RESET;
         stby_q     <= 1'b0;
         ovr_q      <= 1'b0;
      end else begin
         tgl_prev_q <= hw_mode_s ? 1'b0 : upd_tgl_s;
         cfg_q      <= cfg_d;
         stby_q     <= stby_d;
         ovr_q      <= overrange_flag_i;
      end
   end

   // ==========================================================
   // outputs
   assign overrange_or_readback_out_o = regs_q[0][CSP_CTRL_RDSEL] ?
                                        rb_shift_q[CSP_DATA_BITS-1] : ovr_q;
   assign hw_mode_o  = hw_mode_s;
   assign standby_o  = stby_q;
   assign cfg_gen0_o = cfg_q.gen0;
   assign cfg_gen1_o = cfg_q.gen1;
endmodule

// [dv/csp_host.sv]
/* host model driving the serial configuration pins.
   assumes the bench sequences frames; link clock runs only inside frames. */
`timescale 1ns/1ps
module csp_host
   import csp_pkg::*;
(
   // serial pins
   output logic          sck_o,
   output logic          sd_o,
   output logic          en_n_o,
   input  wire logic     rdbk_i
);
   // ==========
   // frames
   initial begin
      sck_o = 1'b0;
      en_n_o = 1'b1;
      sd_o = 1'b0;
   end
   task automatic level(input logic v);
      sd_o = v;
   endtask
   task automatic frame(input csp_frame_type f, input int n, input logic en,
                        output logic [7:0] rd);
      rd = 8'h00;
      en_n_o = !en;
      #24;
      for (int i = 15; i > 15 - n; i--) begin
         sd_o = f[i];
         #24 sck_o = 1'b1;
         #24 sck_o = 1'b0;
         if (i inside {[1:8]}) rd[i-1] = rdbk_i;
      end
      en_n_o = 1'b1;
      sd_o = 1'b0;
      #24;
   endtask
endmodule

// [dv/csp_port_chk.sv]
/* port assertions for csp_port.
   assumes all checks run on sys_clk_i and stop under sys_rst_i. */
`timescale 1ns/1ps
module csp_port_chk (
   // watched ports
   input wire logic       sys_clk_i,
   input wire logic       sys_rst_i,
   input wire logic       config_reset_pin_i,
   input wire logic       config_serial_data_in_i,
   input wire logic       config_serial_enable_n_i,
   input wire logic       overrange_or_readback_out_o,
   input wire logic       overrange_flag_i,
   input wire logic       hw_mode_o,
   input wire logic       standby_o,
   input wire logic [7:0] cfg_gen0_o,
   input wire logic [7:0] cfg_gen1_o
);
   // ==========
   // checks
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence hw_held; hw_mode_o[*2]; endsequence
   sequence pin_held; config_reset_pin_i[*5]; endsequence
   ovr_pass_a: assert property (hw_held |-> overrange_or_readback_out_o == $past(overrange_flag_i))
      else $error("pin not showing overrange");
   hw_sync_a: assert property ($changed(config_reset_pin_i) |-> ##2 hw_mode_o == $past(config_reset_pin_i, 2))
      else $error("mode not following reset pin");
   cfg_hold_a: assert property (hw_held |-> cfg_gen0_o == 8'h00 && cfg_gen1_o == 8'h00)
      else $error("cfg not default in pin mode");
   stby_pin_a: assert property ((hw_mode_o && $stable(config_serial_data_in_i))[*5]
      |-> standby_o == config_serial_data_in_i)
      else $error("standby not following data pin");
   quiet_cfg_a: assert property ((config_serial_enable_n_i && !hw_mode_o)[*6]
      |-> $stable(cfg_gen0_o) && $stable(cfg_gen1_o))
      else $error("cfg changed without enable");
   sclk_ign_a: assert property (pin_held |-> $stable(cfg_gen0_o) && $stable(cfg_gen1_o))
      else $error("cfg changed in pin mode");
endmodule

// [dv/csp_port_tb.sv]
/* bench for csp_port; host model on the serial pins.
   assumes the checker is bound below. */
`timescale 1ns/1ps
module csp_port_tb;
   import csp_pkg::*;
   logic       sys_clk_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic       pin = 1'b0;
   logic       ovr = 1'b0;
   logic       sck, sd, en_n, out, hw, stby;
   logic [7:0] g0, g1, rd;
   int         errors = 0;
   int         n_checks = 0;
   always #2.5 sys_clk_i = ~sys_clk_i;
   csp_host host_u (.sck_o(sck), .sd_o(sd), .en_n_o(en_n), .rdbk_i(out));
   csp_port dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .config_reset_pin_i(pin),
      .config_serial_clk_i(sck), .config_serial_data_in_i(sd), .config_serial_enable_n_i(en_n),
      .overrange_or_readback_out_o(out), .overrange_flag_i(ovr), .hw_mode_o(hw),
      .standby_o(stby), .cfg_gen0_o(g0), .cfg_gen1_o(g1));
   // ==========
   // helpers
   task automatic chk(input string nm, input logic [7:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic results;
      $display("checks %0d, errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d);
      host_u.frame({a, d}, 16, 1'b1, rd);
      repeat (6) @(posedge sys_clk_i);
   endtask
   // ==========
   // scenarios
   task automatic t_write;
      pin <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      pin <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      wr(CSP_ADDR_GEN0, 8'hA5);
      wr(CSP_ADDR_GEN1, 8'h3C);
      chk("gen0", g0, 8'hA5);
      host_u.frame({CSP_ADDR_GEN0, 8'h11}, 12, 1'b1, rd);
      host_u.frame({CSP_ADDR_GEN1, 8'h22}, 16, 1'b0, rd);
      repeat (6) @(posedge sys_clk_i);
      chk("gen0 abort", g0, 8'hA5);
      chk("gen1 idle", g1, 8'h3C);
   endtask
   task automatic t_rdbk;
      wr(CSP_ADDR_CTRL, 8'h02);
      wr(CSP_ADDR_GEN0, 8'h00);
      chk("readback", rd, 8'hA5);
      wr(CSP_ADDR_CTRL, 8'h00);
      ovr <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      chk("ovr pin", {7'h00, out}, 8'h01);
      ovr <= 1'b0;
   endtask
   task automatic t_hw;
      pin <= 1'b1;
      host_u.frame({CSP_ADDR_GEN1, 8'hFF}, 16, 1'b1, rd);
      host_u.level(1'b1);
      repeat (6) @(posedge sys_clk_i);
      chk("standby pin", {7'h00, stby}, 8'h01);
      chk("gen1 held", g1, 8'h00);
      chk("hw mode on", {7'h00, hw}, 8'h01);
      host_u.level(1'b0);
      pin <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      chk("hw mode off", {7'h00, hw}, 8'h00);
      wr(CSP_ADDR_PWR, 8'h01);
      chk("standby reg", {7'h00, stby}, 8'h01);
      wr(CSP_ADDR_CTRL, 8'h01);
      chk("soft reset", {7'h00, stby}, 8'h00);
   endtask
   initial begin
      #100000;
      errors++;
      results;
   end
   initial begin
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      t_write;
      t_rdbk;
      t_hw;
      results;
   end
endmodule
bind csp_port csp_port_chk chk_u (.*);
